// file: dbsio_pkg.sv
// Constants and types shared by the data-bus-shared I/O port.
// Assumes a 16-bit register address space and 8-bit register data.
package dbsio_pkg;

    // Port width and register data width
    localparam int unsigned PORT_WIDTH = 8;

    // Register offsets (lower 16 bits of the address)
    localparam logic [15:0] PULLUP_CONTROL_OFFSET = 16'hFFAE;
    localparam logic [15:0] PIN_DIRECTION_OFFSET  = 16'hFFB4;
    localparam logic [15:0] OUTPUT_LATCH_OFFSET   = 16'hFFB6;
    localparam logic [15:0] PORT_STATUS_OFFSET    = 16'hFFA0;

    // Reset values
    localparam logic [7:0] PULLUP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PIN_DIRECTION_RESET  = 8'h00;
    localparam logic [7:0] OUTPUT_LATCH_RESET   = 8'h00;

    // Value returned for the write-only direction register and for holes
    localparam logic [7:0] DIRECTION_READ_VALUE = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

    // Operating mode that is always expanded
    localparam logic [1:0] MODE_ALWAYS_EXPANDED = 2'h1;

    // Status register field positions
    localparam int unsigned STATUS_EXPANDED_BIT = 0;
    localparam int unsigned STATUS_POWER_LSB    = 1;
    localparam int unsigned STATUS_MODE_LSB     = 4;

    // Power state of the port
    typedef enum logic [1:0] {
        DBSIO_PWR_RUN     = 2'b00,
        DBSIO_PWR_SW_STBY = 2'b01,
        DBSIO_PWR_HW_STBY = 2'b10
    } dbsio_power_t;

endpackage : dbsio_pkg

// file: dbsio_reg8.sv
// One software register with reset value, synchronous clear and write.
// Assumes clear and write come from the same clock domain.
module dbsio_reg8 #(
    parameter int unsigned      WIDTH       = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             write_en,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] value
);

    logic [WIDTH-1:0] next_value;

    // Clear beats a write so hardware standby always lands on the reset value
    always_comb begin
        next_value = value;
        if (clear) begin
            next_value = RESET_VALUE;
        end else if (write_en) begin
            next_value = wdata;
        end
    end

    // Register stage
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            value <= RESET_VALUE;
        end else begin
            value <= next_value;
        end
    end

endmodule // dbsio_reg8

// file: dbsio_pin_mux.sv
// Per-pin selection between data bus and general-purpose port use.
// Purely combinational; the caller registers every result.
module dbsio_pin_mux #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             expanded,
    input  wire logic             quiet,
    input  wire logic             hw_standby,
    input  wire logic [WIDTH-1:0] direction,
    input  wire logic [WIDTH-1:0] latch,
    input  wire logic [WIDTH-1:0] pullup_ctl,
    input  wire logic             bus_drive,
    input  wire logic [WIDTH-1:0] bus_dout,
    output logic      [WIDTH-1:0] drive_value,
    output logic      [WIDTH-1:0] drive_oe_n,
    output logic      [WIDTH-1:0] pullup_on
);

    // Expanded: bus controller owns the pins; single chip: direction decides
    always_comb begin
        drive_value = '0;
        drive_oe_n  = '1;
        pullup_on   = '0;
        if (expanded) begin
            if (!quiet && bus_drive) begin
                drive_value = bus_dout;
                drive_oe_n  = '0;
            end
            // Bus pins float in standby and pull-ups stay off
        end else if (!hw_standby) begin
            drive_value = latch & direction;
            drive_oe_n  = ~direction;
            pullup_on   = pullup_ctl & ~direction;
        end
    end

endmodule // dbsio_pin_mux

// file: dbsio_port.sv
// Top of the 8-bit general-purpose port that doubles as the data bus.
// Assumes pins and mode inputs are synchronous to clock; the pad ring
// resolves each pin from pin_out and pin_oe_n and applies pullup_en.
module dbsio_port #(
    parameter int unsigned WIDTH = dbsio_pkg::PORT_WIDTH
) (
    input  wire logic             clock,
    input  wire logic             reset,
    // Operating mode and power state
    input  wire logic [1:0]       operating_mode,
    input  wire logic             expanded_mode_select,
    input  wire logic             hw_standby,
    input  wire logic             sw_standby,
    // Register port
    input  wire logic [15:0]      reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic      [7:0]       reg_rdata,
    // External bus controller side
    input  wire logic             ext_bus_drive,
    input  wire logic [WIDTH-1:0] ext_bus_dout,
    output logic      [WIDTH-1:0] ext_bus_din,
    // Pins
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out,
    output logic      [WIDTH-1:0] pin_oe_n,
    output logic      [WIDTH-1:0] pullup_en
);

    // Address decode, shared by the read and write paths
    function automatic logic addr_is(input logic [15:0] addr,
                                     input logic [15:0] offset);
        addr_is = (addr == offset);
    endfunction

    // Widen or trim a port-width value to the 8-bit register data path
    function automatic logic [7:0] to_byte(input logic [WIDTH-1:0] v);
        logic [7:0] b;
        b = '0;
        for (int i = 0; i < WIDTH && i < 8; i++) begin
            b[i] = v[i];
        end
        to_byte = b;
    endfunction

    // Mode decoding
    logic expanded;
    logic quiet;

    // Expanded when in the always-expanded mode or when the select is set
    always_comb begin
        expanded = (operating_mode == dbsio_pkg::MODE_ALWAYS_EXPANDED) ||
                   expanded_mode_select;
        quiet    = hw_standby || sw_standby;
    end

    // Power state tracking
    dbsio_pkg::dbsio_power_t power_state;
    dbsio_pkg::dbsio_power_t next_power_state;

    // Hardware standby dominates software standby
    always_comb begin
        case (power_state)
            dbsio_pkg::DBSIO_PWR_RUN,
            dbsio_pkg::DBSIO_PWR_SW_STBY,
            dbsio_pkg::DBSIO_PWR_HW_STBY: begin
                if (hw_standby) begin
                    next_power_state = dbsio_pkg::DBSIO_PWR_HW_STBY;
                end else if (sw_standby) begin
                    next_power_state = dbsio_pkg::DBSIO_PWR_SW_STBY;
                end else begin
                    next_power_state = dbsio_pkg::DBSIO_PWR_RUN;
                end
            end
            default: begin
                next_power_state = dbsio_pkg::DBSIO_PWR_RUN;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            power_state <= dbsio_pkg::DBSIO_PWR_RUN;
        end else begin
            power_state <= next_power_state;
        end
    end

    // Register write decode
    logic wr_direction;
    logic wr_latch;
    logic wr_pullup;

    // Software standby clears no register, so writes are still accepted
    always_comb begin
        wr_direction = reg_write && addr_is(reg_addr, dbsio_pkg::PIN_DIRECTION_OFFSET);
        wr_latch     = reg_write && addr_is(reg_addr, dbsio_pkg::OUTPUT_LATCH_OFFSET);
        wr_pullup    = reg_write && addr_is(reg_addr, dbsio_pkg::PULLUP_CONTROL_OFFSET);
    end

    // Software registers
    logic [WIDTH-1:0] pin_direction;
    logic [WIDTH-1:0] output_latch;
    logic [WIDTH-1:0] pullup_control;

    // Direction bits: cleared by reset and hardware standby
    dbsio_reg8 #(
        .WIDTH       (WIDTH),
        .RESET_VALUE (WIDTH'(dbsio_pkg::PIN_DIRECTION_RESET))
    ) u_direction (
        .clock    (clock),
        .reset    (reset),
        .clear    (hw_standby),
        .write_en (wr_direction),
        .wdata    (reg_wdata[WIDTH-1:0]),
        .value    (pin_direction)
    );

    // Output latch: cleared by reset and hardware standby
    dbsio_reg8 #(
        .WIDTH       (WIDTH),
        .RESET_VALUE (WIDTH'(dbsio_pkg::OUTPUT_LATCH_RESET))
    ) u_latch (
        .clock    (clock),
        .reset    (reset),
        .clear    (hw_standby),
        .write_en (wr_latch),
        .wdata    (reg_wdata[WIDTH-1:0]),
        .value    (output_latch)
    );

    // Pull-up control: cleared by reset and hardware standby
    dbsio_reg8 #(
        .WIDTH       (WIDTH),
        .RESET_VALUE (WIDTH'(dbsio_pkg::PULLUP_CONTROL_RESET))
    ) u_pullup (
        .clock    (clock),
        .reset    (reset),
        .clear    (hw_standby),
        .write_en (wr_pullup),
        .wdata    (reg_wdata[WIDTH-1:0]),
        .value    (pullup_control)
    );

    // Pin selection
    logic [WIDTH-1:0] mux_value;
    logic [WIDTH-1:0] mux_oe_n;
    logic [WIDTH-1:0] mux_pullup;

    dbsio_pin_mux #(
        .WIDTH (WIDTH)
    ) u_pin_mux (
        .expanded    (expanded),
        .quiet       (quiet),
        .hw_standby  (hw_standby),
        .direction   (pin_direction),
        .latch       (output_latch),
        .pullup_ctl  (pullup_control),
        .bus_drive   (ext_bus_drive),
        .bus_dout    (ext_bus_dout),
        .drive_value (mux_value),
        .drive_oe_n  (mux_oe_n),
        .pullup_on   (mux_pullup)
    );

    // Pin and bus outputs
    logic [WIDTH-1:0] next_pin_out;
    logic [WIDTH-1:0] next_pin_oe_n;
    logic [WIDTH-1:0] next_pullup_en;
    logic [WIDTH-1:0] next_ext_bus_din;

    // Outputs are registered, so pins follow register writes a cycle late
    always_comb begin
        next_pin_out     = mux_value;
        next_pin_oe_n    = mux_oe_n;
        next_pullup_en   = mux_pullup;
        next_ext_bus_din = expanded ? pin_in : '0;
    end

    // After reset every pin floats and every pull-up is off
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_out     <= '0;
            pin_oe_n    <= '1;
            pullup_en   <= '0;
            ext_bus_din <= '0;
        end else begin
            pin_out     <= next_pin_out;
            pin_oe_n    <= next_pin_oe_n;
            pullup_en   <= next_pullup_en;
            ext_bus_din <= next_ext_bus_din;
        end
    end

    // Read-back
    logic [7:0] port_read_value;
    logic [7:0] status_value;
    logic [7:0] next_reg_rdata;

    // Output bits return the latch, input bits return the pin level
    always_comb begin
        port_read_value = to_byte((output_latch & pin_direction) |
                                  (pin_in & ~pin_direction));
        status_value = '0;
        status_value[dbsio_pkg::STATUS_EXPANDED_BIT] = expanded;
        status_value[dbsio_pkg::STATUS_POWER_LSB +: 2] = power_state;
        status_value[dbsio_pkg::STATUS_MODE_LSB +: 2] = operating_mode;
    end

    // Read data stands for one cycle after the strobe, zero otherwise
    always_comb begin
        next_reg_rdata = '0;
        if (reg_read) begin
            if (addr_is(reg_addr, dbsio_pkg::OUTPUT_LATCH_OFFSET)) begin
                next_reg_rdata = port_read_value;
            end else if (addr_is(reg_addr, dbsio_pkg::PULLUP_CONTROL_OFFSET)) begin
                next_reg_rdata = to_byte(pullup_control);
            end else if (addr_is(reg_addr, dbsio_pkg::PIN_DIRECTION_OFFSET)) begin
                // Stored bits are never exposed; a fixed pattern stands in
                next_reg_rdata = dbsio_pkg::DIRECTION_READ_VALUE;
            end else if (addr_is(reg_addr, dbsio_pkg::PORT_STATUS_OFFSET)) begin
                next_reg_rdata = status_value;
            end else begin
                next_reg_rdata = dbsio_pkg::UNMAPPED_READ_VALUE;
            end
        end
    end

    // Read data register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule // dbsio_port

// file: dbsio_port_asserts.sv
// Concurrent checks on the ports of the data-bus-shared I/O port.
// Assumes one clock domain and is attached by the bind at the foot.
module dbsio_port_asserts #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic             clock,
    input wire logic             reset,
    input wire logic [1:0]       operating_mode,
    input wire logic             expanded_mode_select,
    input wire logic             hw_standby,
    input wire logic             sw_standby,
    input wire logic [15:0]      reg_addr,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [7:0]       reg_rdata,
    input wire logic             ext_bus_drive,
    input wire logic [WIDTH-1:0] ext_bus_dout,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [WIDTH-1:0] pullup_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // Mode 1 is expanded whatever the select says
    logic ex;
    assign ex = (operating_mode == 2'h1) || expanded_mode_select;

    a_dir_read_ff: assert property (reg_read && reg_addr == 16'hFFB4
        |=> reg_rdata == 8'hFF)
        else $error("direction read value wrong");
    a_bus_drives_pins: assert property (ex && ext_bus_drive && !hw_standby && !sw_standby
        |=> pin_oe_n == 8'h00 && pin_out == $past(ext_bus_dout))
        else $error("bus drive not on pins");
    a_bus_idle_float: assert property (ex && !ext_bus_drive |=> pin_oe_n == 8'hFF)
        else $error("idle bus pins driven");
    a_stby_bus_float: assert property (ex && (hw_standby || sw_standby) |=> &pin_oe_n)
        else $error("bus pins driven in standby");
    a_exp_no_pullup: assert property (ex |=> pullup_en == 8'h00)
        else $error("pull-up on in expanded mode");
    a_hw_all_off: assert property (hw_standby |=> pin_oe_n == 8'hFF
        && pullup_en == 8'h00)
        else $error("pins active in hardware standby");
    a_pullup_input: assert property ((pullup_en & ~pin_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    // A quiet cycle after standby lets a plain read follow the release
    a_hw_clears_pcr: assert property (hw_standby ##1 !hw_standby && !reg_write
        ##1 reg_read && reg_addr == 16'hFFAE |=> reg_rdata == 8'h00)
        else $error("pull-up control kept in standby");
    a_hw_clears_dir: assert property (hw_standby ##1 !hw_standby && !ex && !reg_write
        |=> pin_oe_n == 8'hFF)
        else $error("direction kept in standby");
endmodule // dbsio_port_asserts

bind dbsio_port dbsio_port_asserts #(.WIDTH(WIDTH)) i_dbsio_port_asserts (.*);

// file: dbsio_bus_model.sv
// Memory or peripheral sitting on the shared data lines.
// Assumes the pad resolves port drive over device drive over pull-up.
module dbsio_bus_model (
    input  wire logic       clock,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pullup_en,
    input  wire logic       dev_drive,
    input  wire logic [7:0] dev_data,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last = 8'h00;

    // A line nobody drives flips each cycle so a stale value never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (dev_drive) pin_in[i] = dev_data[i];
            else if (pullup_en[i]) pin_in[i] = 1'b1;
            else pin_in[i] = ~last[i];
        end
    end

    // Remember the last level of every line
    always_ff @(posedge clock) last <= pin_in;
endmodule // dbsio_bus_model

// file: dbsio_port_tb_top.sv
// Self-checking bench for the data-bus-shared I/O port.
// Assumes the bus model stands on the pins and the checker is bound.
module dbsio_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] md;
        logic       sel, ddrv, bdrv;
        logic [7:0] dir, lat, pcr, dd, bd, oe, po, pu, rd, din;
    } dbsio_row_t;
    // Mode, select, device drive, bus drive, regs, device and bus data, expectations
    localparam dbsio_row_t ROWS [5] = '{
        '{2'h2, 1'b0, 1'b1, 1'b0, 8'hF0, 8'hA5, 8'h0F, 8'h3C, 8'h00,
          8'h0F, 8'hA0, 8'h0F, 8'hAC, 8'h00},
        '{2'h3, 1'b0, 1'b1, 1'b0, 8'h03, 8'h55, 8'h0F, 8'h00, 8'h00,
          8'hFC, 8'h01, 8'h0C, 8'h01, 8'h00},
        '{2'h2, 1'b1, 1'b1, 1'b0, 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'h00,
          8'hFF, 8'h00, 8'h00, 8'h00, 8'h5A},
        '{2'h1, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hC3,
          8'h00, 8'hC3, 8'h00, 8'h00, 8'hC3},
        '{2'h0, 1'b0, 1'b1, 1'b1, 8'hFF, 8'h96, 8'hFF, 8'h00, 8'h11,
          8'h00, 8'h96, 8'h00, 8'h96, 8'h00}};
    logic clock = 1'b0, reset = 1'b1, expanded_mode_select = 1'b0;
    logic hw_standby = 1'b0, sw_standby = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic ext_bus_drive = 1'b0, dev_drive = 1'b1;
    logic [1:0]  operating_mode = 2'h2;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, ext_bus_dout = 8'h00, dev_data = 8'h00, v;
    logic [7:0]  reg_rdata, ext_bus_din, pin_in, pin_out, pin_oe_n, pullup_en;
    int          n_mismatch = 0, num_checks = 0;
    dbsio_row_t  r;

    dbsio_port #(.WIDTH(8)) i_dbsio_port (.*);
    dbsio_bus_model i_dbsio_bus_model (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .dev_drive(dev_drive), .dev_data(dev_data), .pin_in(pin_in));

    // Free-running 8 ns clock
    initial begin
        forever #4 clock = ~clock;
    end

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Cut a hang short well past the expected 122 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        // Table of ordinary configurations
        foreach (ROWS[k]) begin
            // Inputs move only on a rising edge
            @(posedge clock);
            r = ROWS[k];
            operating_mode <= r.md;
            expanded_mode_select <= r.sel;
            dev_drive <= r.ddrv;
            dev_data <= r.dd;
            ext_bus_drive <= r.bdrv;
            ext_bus_dout <= r.bd;
            wr(16'hFFB4, r.dir);
            wr(16'hFFB6, r.lat);
            wr(16'hFFAE, r.pcr);
            settle();
            chk("oe", pin_oe_n, r.oe);
            chk("out", pin_out & ~pin_oe_n, r.po);
            chk("pullup", pullup_en, r.pu);
            chk("din", ext_bus_din, r.din);
            if (r.md != 2'h1 && !r.sel) begin
                rd(16'hFFB6, v);
                chk("data", v, r.rd);
            end
        end
        // Write-only and unmapped places
        @(posedge clock);
        operating_mode <= 2'h2;
        rd(16'hFFB4, v);
        chk("dir read", v, 8'hFF);
        wr(16'hFFB0, 8'h77);
        rd(16'hFFB0, v);
        chk("hole", v, 8'h00);
        // Software standby keeps state; expanded pins float
        @(posedge clock);
        sw_standby <= 1'b1;
        settle();
        chk("sw oe", pin_oe_n, 8'h00);
        rd(16'hFFB6, v);
        chk("sw data", v, 8'h96);
        rd(16'hFFAE, v);
        chk("sw pcr", v, 8'hFF);
        @(posedge clock);
        expanded_mode_select <= 1'b1;
        settle();
        chk("sw bus oe", pin_oe_n, 8'hFF);
        // Status: expanded, software standby, mode 2
        rd(16'hFFA0, v);
        chk("status", v, 8'h23);
        @(posedge clock);
        sw_standby <= 1'b0;
        settle();
        chk("bus out", pin_out, 8'h11);
        // Hardware standby clears and loses writes
        @(posedge clock);
        expanded_mode_select <= 1'b0;
        hw_standby <= 1'b1;
        wr(16'hFFB6, 8'hAA);
        settle();
        chk("hw oe", pin_oe_n, 8'hFF);
        chk("hw pullup", pullup_en, 8'h00);
        @(posedge clock);
        hw_standby <= 1'b0;
        rd(16'hFFAE, v);
        chk("hw pcr", v, 8'h00);
        settle();
        chk("hw dir", pin_oe_n, 8'hFF);
        wr(16'hFFB4, 8'hFF);
        settle();
        chk("hw latch", pin_out, 8'h00);
        // Second reset in mid-run
        wr(16'hFFAE, 8'h55);
        reset <= 1'b1;
        settle();
        chk("rst oe", pin_oe_n, 8'hFF);
        @(posedge clock);
        reset <= 1'b0;
        rd(16'hFFAE, v);
        chk("rst pcr", v, 8'h00);
        wr(16'hFFB4, 8'hFF);
        rd(16'hFFB6, v);
        chk("rst data", v, 8'h00);
        summarize();
    end
endmodule // dbsio_port_tb_top
